// ==== core/pgen_consts.svh ====
// Register offsets, field positions and reset values of the period and status block
`ifndef PGEN_CONSTS_SVH
`define PGEN_CONSTS_SVH

`define PGEN_ADDR_W 12
`define PGEN_OFF_INTEN 12'h044
`define PGEN_OFF_RAWSTAT 12'h048
`define PGEN_OFF_STATUS 12'h04C
`define PGEN_OFF_PERIOD 12'h050
`define PGEN_OFF_COUNT 12'h054
`define PGEN_OFF_CTRL 12'h040
`define PGEN_EVT_W 6
`define PGEN_BIT_CMPB_DOWN 5
`define PGEN_BIT_CMPB_UP 4
`define PGEN_BIT_CMPA_DOWN 3
`define PGEN_BIT_CMPA_UP 2
`define PGEN_BIT_AT_TOP 1
`define PGEN_BIT_AT_ZERO 0
`define PGEN_CTRL_RUN 0
`define PGEN_CTRL_MODE 1
`define PGEN_CTRL_UPDSYNC 2
`define PGEN_PERIOD_RST 16'h0000
`define PGEN_EVT_RST 6'h00

`endif

// ==== core/pgen_pkg.sv ====
// Types shared by the period and status block
package pgen_pkg;
  typedef enum logic [0:0] {
    PGEN_DIR_DOWN = 1'b0,
    PGEN_DIR_UP = 1'b1
  } pgen_dir_t;
endpackage : pgen_pkg

// ==== core/pgen_period_irq.sv ====
// Generator counter with period reload and latched interrupt status, APB slave
// ----------------------------------------------------------------------------
// How it works
// - Status holds latched flag per event
// - Status shows only enabled latched events
// - Write one clears, zero leaves bit
// - Flag positions five down to zero
// - Reserved bits read zero, writes ignored
// - Period register sixteen bits, resets zero
// - Count-down reloads period at zero
// - Up/down counts zero to period, back
// - Immediate mode: new period at next zero
// - Sync mode: zero after update request
// - Rewrite discards earlier pending period
// - Up compare events only in up/down
// - Each event has own enable bit
// ----------------------------------------------------------------------------
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "pgen_consts.svh"

module pgen_period_irq
  import pgen_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CNT_W-1:0] cmpA,
  input wire logic [CNT_W-1:0] cmpB,
  input wire logic syncUpdateReq,
  output logic irq,
  output logic counterAtZero,
  output logic counterAtTop,
  output logic [CNT_W-1:0] counterValue
);

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic access;
  logic wrEn;
  logic rdEn;
  logic [`PGEN_ADDR_W-1:0] addr;
  logic hit;

  assign access = psel && penable && pready;
  assign wrEn = access && pwrite;
  assign rdEn = access && !pwrite;
  assign addr = paddr[`PGEN_ADDR_W-1:0];

  function automatic logic isMapped(input logic [`PGEN_ADDR_W-1:0] a);
    return (a == `PGEN_OFF_CTRL) || (a == `PGEN_OFF_INTEN) || (a == `PGEN_OFF_RAWSTAT)
      || (a == `PGEN_OFF_STATUS) || (a == `PGEN_OFF_PERIOD) || (a == `PGEN_OFF_COUNT);
  endfunction : isMapped

  assign hit = isMapped(addr) && (paddr[31:`PGEN_ADDR_W] == '0);

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  logic [2:0] ctrl;
  logic [`PGEN_EVT_W-1:0] evtEnable;
  logic [CNT_W-1:0] periodWritten;
  logic [CNT_W-1:0] periodActive;
  logic periodPending;
  logic syncArmed;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= 3'h0;
      evtEnable <= `PGEN_EVT_RST;
    end
    else if (wrEn && addr == `PGEN_OFF_CTRL)
    begin
      ctrl <= pwdata[2:0];
    end
    else if (wrEn && addr == `PGEN_OFF_INTEN)
    begin
      evtEnable <= pwdata[`PGEN_EVT_W-1:0];
    end
  end

  // A rewrite simply replaces the staged value, so an older one never reaches the counter
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      periodWritten <= `PGEN_PERIOD_RST;
    end
    else if (wrEn && addr == `PGEN_OFF_PERIOD)
    begin
      periodWritten <= pwdata[CNT_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  pgen_dir_t dir;
  logic atZero;
  logic atTop;
  logic run;
  logic upDownMode;

  assign run = ctrl[`PGEN_CTRL_RUN];
  assign upDownMode = ctrl[`PGEN_CTRL_MODE];
  assign atZero = run && (counterValue == '0);
  assign atTop = run && (counterValue == periodActive);

  // Sync request is remembered until the zero that applies it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncArmed <= 1'b0;
    end
    else if (atZero && syncArmed)
    begin
      syncArmed <= syncUpdateReq;
    end
    else if (syncUpdateReq)
    begin
      syncArmed <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      periodPending <= 1'b0;
    end
    else if (wrEn && addr == `PGEN_OFF_PERIOD)
    begin
      periodPending <= 1'b1;
    end
    else if (atZero && (!ctrl[`PGEN_CTRL_UPDSYNC] || syncArmed))
    begin
      periodPending <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      periodActive <= `PGEN_PERIOD_RST;
    end
    else if (atZero && periodPending && !ctrl[`PGEN_CTRL_UPDSYNC])
    begin
      periodActive <= periodWritten;
    end
    else if (atZero && periodPending && syncArmed)
    begin
      periodActive <= periodWritten;
    end
  end

  // Reload uses the value that is active after this zero's update
  logic [CNT_W-1:0] reloadValue;
  assign reloadValue = (periodPending && (!ctrl[`PGEN_CTRL_UPDSYNC] || syncArmed))
    ? periodWritten : periodActive;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      counterValue <= '0;
      dir <= PGEN_DIR_UP;
    end
    else if (!run)
    begin
      counterValue <= '0;
      dir <= PGEN_DIR_UP;
    end
    else if (!upDownMode)
    begin
      dir <= PGEN_DIR_DOWN;
      counterValue <= atZero ? reloadValue : counterValue - 1'b1;
    end
    else if (atZero)
    begin
      dir <= PGEN_DIR_UP;
      counterValue <= (reloadValue == '0) ? '0 : CNT_W'(1);
    end
    else if (atTop || dir == PGEN_DIR_DOWN)
    begin
      dir <= PGEN_DIR_DOWN;
      counterValue <= counterValue - 1'b1;
    end
    else
    begin
      counterValue <= counterValue + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Events and status
  // --------------------------------------------------------------------------
  logic [`PGEN_EVT_W-1:0] evt;
  logic [`PGEN_EVT_W-1:0] rawFlags;
  logic [`PGEN_EVT_W-1:0] clearMask;
  logic countingUp;

  // Up direction exists only in up/down mode, and not at the turn-around top
  assign countingUp = upDownMode && (dir == PGEN_DIR_UP) && !atTop;

  always_comb
  begin
    evt = '0;
    evt[`PGEN_BIT_AT_ZERO] = atZero;
    evt[`PGEN_BIT_AT_TOP] = atTop;
    evt[`PGEN_BIT_CMPA_UP] = run && (counterValue == cmpA) && countingUp;
    evt[`PGEN_BIT_CMPA_DOWN] = run && (counterValue == cmpA) && !countingUp;
    evt[`PGEN_BIT_CMPB_UP] = run && (counterValue == cmpB) && countingUp;
    evt[`PGEN_BIT_CMPB_DOWN] = run && (counterValue == cmpB) && !countingUp;
  end

  assign clearMask = (wrEn && addr == `PGEN_OFF_STATUS) ? pwdata[`PGEN_EVT_W-1:0] : '0;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rawFlags <= `PGEN_EVT_RST;
    end
    else
    begin
      rawFlags <= (rawFlags & ~clearMask) | evt;
    end
  end

  // --------------------------------------------------------------------------
  // Read data, answer and outputs
  // --------------------------------------------------------------------------
  logic [31:0] next_prdata;

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    unique case (addr)
      `PGEN_OFF_CTRL: next_prdata[2:0] = ctrl;
      `PGEN_OFF_INTEN: next_prdata[`PGEN_EVT_W-1:0] = evtEnable;
      `PGEN_OFF_RAWSTAT: next_prdata[`PGEN_EVT_W-1:0] = rawFlags;
      `PGEN_OFF_STATUS: next_prdata[`PGEN_EVT_W-1:0] = rawFlags & evtEnable;
      `PGEN_OFF_PERIOD: next_prdata[CNT_W-1:0] = periodWritten;
      `PGEN_OFF_COUNT: next_prdata[CNT_W-1:0] = counterValue;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // No wait state: ready in the first access cycle, data registered with it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite && hit) ? next_prdata : 32'h0000_0000;
      pslverr <= psel && !penable && !hit;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq <= 1'b0;
      counterAtZero <= 1'b0;
      counterAtTop <= 1'b0;
    end
    else
    begin
      irq <= |(((rawFlags & ~clearMask) | evt) & evtEnable);
      counterAtZero <= atZero;
      counterAtTop <= atTop;
    end
  end

endmodule : pgen_period_irq

// ==== tb/pgen_period_irq_checker.sv ====
// Concurrent checks on the ports of the period and status block
`timescale 1ns/100ps
`include "pgen_consts.svh"
module pgen_period_irq_checker #(
  parameter int CNT_W = 16
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic counterAtZero,
  input wire logic counterAtTop,
  input wire logic [CNT_W-1:0] counterValue
);
  logic [5:0] en;
  logic [2:0] ctl;
  wire wr = psel && penable && pready && pwrite;
  // ----
  // Shadows of enable and control, kept from completed writes
  // ----
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      en <= 6'h00;
    else if (wr && paddr[11:0] == `PGEN_OFF_INTEN)
      en <= pwdata[5:0];
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      ctl <= 3'h0;
    else if (wr && paddr[11:0] == `PGEN_OFF_CTRL)
      ctl <= pwdata[2:0];
  sequence s_rd(logic [11:0] off);
    pready && !pwrite && paddr[11:0] == off;
  endsequence
  property p_step;
    counterValue != $past(counterValue) && counterValue != '0 |->
      $past(counterValue) == '0 || counterValue == $past(counterValue) + 1'b1 ||
      counterValue == $past(counterValue) - 1'b1;
  endproperty
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_unmapped_refused: assert property (pready && paddr[11:0] > 12'h054 |-> pslverr)
    else $error("unmapped access answered without error");
  a_status_masked: assert property (s_rd(`PGEN_OFF_STATUS) |-> (prdata[5:0] & ~en) == 6'h00)
    else $error("status shows a disabled source");
  a_status_rsvd: assert property (s_rd(`PGEN_OFF_STATUS) |-> prdata[31:6] == 26'h0)
    else $error("status upper bits not zero");
  a_period_rsvd: assert property (s_rd(`PGEN_OFF_PERIOD) |-> prdata[31:16] == 16'h0)
    else $error("period upper bits not zero");
  a_zero_event: assert property (counterAtZero |-> $past(counterValue) == '0)
    else $error("zero event without zero count");
  a_counter_step: assert property (p_step)
    else $error("counter jumped");
  a_top_turn: assert property (counterAtTop && ctl[1:0] == 2'h3 |->
    counterValue == $past(counterValue) - 1'b1)
    else $error("counter did not turn down at top");
  a_irq_masked: assert property (en == 6'h00 && $past(en) == 6'h00 |-> !irq)
    else $error("interrupt with all sources disabled");
endmodule : pgen_period_irq_checker

bind pgen_period_irq pgen_period_irq_checker #(.CNT_W(CNT_W)) u_chk (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .counterAtZero(counterAtZero),
  .counterAtTop(counterAtTop), .counterValue(counterValue));

// ==== tb/pgen_period_irq_tb_top.sv ====
// Self-checking bench for the period and status block
`timescale 1ns/100ps
`include "pgen_consts.svh"
module pgen_period_irq_tb_top;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic syncUpdateReq = 1'b0, pready, pslverr, irq, atZero, atTop;
  logic [31:0] paddr = '0, pwdata = '0, prdata, seed = 32'h00000058;
  logic [15:0] cmpA = '0, cmpB = '0, counterValue, pk;
  logic [32:0] q[$];
  int failCount = 0, testsRun = 0, cyc = 0;
  always #5 clk = ~clk;
  pgen_period_irq #(.CNT_W(16)) uut (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmpA(cmpA), .cmpB(cmpB),
    .syncUpdateReq(syncUpdateReq), .irq(irq), .counterAtZero(atZero),
    .counterAtTop(atTop), .counterValue(counterValue));
  // ----
  // Shared tasks
  // ----
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic closeOut;
    $display("checks=%0d errors=%0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : closeOut
  // Request is held until pready has been seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {20'h00000, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic runPk(input int n);
    pk = '0;
    repeat (n)
    begin
      @(posedge clk);
      if (counterValue > pk)
        pk = counterValue;
    end
  endtask : runPk
  // Values seen at the edge are the ones before that edge's updates
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, q.pop_front());
    cyc++;
    if (cyc == 3000)
    begin
      failCount++;
      closeOut();
    end
  end
  // ----
  // Scenarios
  // ----
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(`PGEN_OFF_PERIOD, 33'h0);
    rd(`PGEN_OFF_STATUS, 33'h0);
    rd(12'h100, 33'h100000000);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      apb(1'b1, `PGEN_OFF_PERIOD, {16'h0000, seed[15:0]});
      rd(`PGEN_OFF_PERIOD, {17'h0, seed[15:0]});
    end
    apb(1'b1, `PGEN_OFF_PERIOD, 32'h5);
    cmpA <= 16'h2;
    cmpB <= 16'h3;
    apb(1'b1, `PGEN_OFF_INTEN, 32'h3F);
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, `PGEN_OFF_CTRL, m ? 32'h3 : 32'h1);
      repeat (30) @(posedge clk);
      apb(1'b1, `PGEN_OFF_CTRL, 32'h0);
      rd(`PGEN_OFF_RAWSTAT, m ? 33'h3F : 33'h2B);
      apb(1'b1, `PGEN_OFF_INTEN, 32'h0F);
      rd(`PGEN_OFF_STATUS, m ? 33'h0F : 33'h0B);
      chk({32'h0, irq}, 33'h1);
      apb(1'b1, `PGEN_OFF_STATUS, 32'h1);
      rd(`PGEN_OFF_RAWSTAT, m ? 33'h3E : 33'h2A);
      apb(1'b1, `PGEN_OFF_STATUS, 32'h3F);
      rd(`PGEN_OFF_RAWSTAT, 33'h0);
      chk({32'h0, irq}, 33'h0);
      apb(1'b1, `PGEN_OFF_INTEN, 32'h3F);
    end
    apb(1'b1, `PGEN_OFF_INTEN, 32'h0);
    apb(1'b1, `PGEN_OFF_CTRL, 32'h5);
    apb(1'b1, `PGEN_OFF_PERIOD, 32'h9);
    apb(1'b1, `PGEN_OFF_PERIOD, 32'h7);
    rd(`PGEN_OFF_PERIOD, 33'h7);
    runPk(30);
    chk({17'h0, pk}, 33'h5);
    syncUpdateReq <= 1'b1;
    @(posedge clk);
    syncUpdateReq <= 1'b0;
    runPk(40);
    chk({17'h0, pk}, 33'h7);
    apb(1'b1, `PGEN_OFF_CTRL, 32'h1);
    apb(1'b1, `PGEN_OFF_PERIOD, 32'h3);
    runPk(10);
    runPk(20);
    chk({17'h0, pk}, 33'h3);
    apb(1'b1, `PGEN_OFF_PERIOD, 32'h0);
    repeat (6) @(posedge clk);
    apb(1'b1, `PGEN_OFF_STATUS, 32'h3F);
    // A one-cycle compare match lands in the access cycle of the clear
    fork
      apb(1'b1, `PGEN_OFF_STATUS, 32'h8);
      begin
        repeat (2) @(posedge clk);
        cmpA <= 16'h0;
        @(posedge clk);
        cmpA <= 16'h2;
      end
    join
    rd(`PGEN_OFF_RAWSTAT, 33'h0B);
    closeOut();
  end
endmodule : pgen_period_irq_tb_top
